// ===== sim/scpmp_host.sv
`timescale 1ns/1ps
module scpmp_host (
  input  wire logic core_clk, // clock
  input  wire logic rst,      // reset
  input  wire logic stall,    // hold off reading
  input  wire logic rxReady,  // byte taken
  input  wire logic [7:0] txByte, // response byte
  input  wire logic txEoi,    // end flag
  input  wire logic txValid,  // byte available
  output logic [7:0] rxByte,  // program byte
  output logic      rxEoi,    // end flag
  output logic      rxValid,  // byte offered
  output logic      txReady   // reading
);
  // ********************
  // controller model
  // ********************
  logic       pace = 1'b0;
  logic [8:0] got[$];
  initial rxByte = 8'h00;
  initial rxEoi = 1'b0;
  initial rxValid = 1'b0;
  // slow reader: one byte every other cycle at best
  assign txReady = !stall && pace;
  always @(posedge core_clk)
  begin
    pace <= !pace;
    if (txValid && txReady) got.push_back({txEoi, txByte});
  end
  task automatic send(input string s, input logic eoi);
    for (int i = 0; i < s.len(); i++)
    begin
      @(negedge core_clk);
      rxByte = s[i];
      rxEoi = eoi && i == s.len() - 1;
      rxValid = 1'b1;
      for (int k = 0; k < 50 && !rxReady; k++) @(negedge core_clk);
      @(posedge core_clk);
    end
    @(negedge core_clk);
    rxValid = 1'b0;
    rxEoi = 1'b0;
    // released lines must not look like a held byte
    rxByte = ~rxByte;
  endtask
endmodule // scpmp_host

// ===== sim/scpmp_parser_sva.sv
`timescale 1ns/1ps
module scpmp_parser_sva (
  input wire logic                  core_clk, rst, rxValid, rxReady, // input side
  input wire logic                  cmdValid, pathKnown, cmdReady, synErr, // consumer
  input wire logic                  respValid, respReady, txEoi, txValid, txReady, // output
  input wire scpmp_pkg::scpmp_cmd_s cmd,   // parsed command
  input wire logic [7:0]            txByte // response byte
);
  // ********************
  // rules at the ports
  // ********************
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  AST_SYNERR_ONE: assert property (synErr |=> !synErr)
    else $error("error pulse too long");
  AST_BAD_PATH: assert property (cmdValid && !pathKnown |=> synErr && !cmdValid)
    else $error("unknown path not refused");
  AST_CMD_HOLD: assert property (cmdValid && pathKnown && !cmdReady |=> cmdValid && $stable(cmd))
    else $error("command not held");
  AST_CMD_TAKE: assert property (cmdValid && pathKnown && cmdReady |=> !cmdValid)
    else $error("command not released");
  AST_RX_BLOCK: assert property (cmdValid |-> !rxReady)
    else $error("byte taken while command pending");
  AST_EOI_LF: assert property (txValid && txEoi |-> txByte == scpmp_pkg::CH_LF)
    else $error("end flag on byte other than line feed");
  AST_TX_HOLD: assert property (txValid && !txReady && !rxValid |=> txValid && $stable(txByte))
    else $error("queued byte lost before read");
  AST_RESP_BUSY: assert property (respValid && respReady |=> !respReady)
    else $error("item taken while formatting");
  cover property (cmdValid && cmd.query && cmdReady);
  cover property (synErr);
  cover property (txValid && txEoi && txReady);
endmodule // scpmp_parser_sva
bind scpmp_parser scpmp_parser_sva scpmp_parser_sva_i (.*);

// ===== sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  // ********************
  // harness
  // ********************
  logic core_clk = 1'b0, rst = 1'b1, stall = 1'b1, cmdReady = 1'b1, respValid = 1'b0;
  logic pathKnown, rxReady, rxEoi, rxValid, cmdValid, synErr, respReady, txEoi, txValid;
  logic txReady;
  logic [7:0] rxByte, txByte;
  scpmp_pkg::scpmp_cmd_s  cmd, got[$];
  scpmp_pkg::scpmp_resp_s resp = '0;
  int err_count = 0, compares = 0, errs = 0, cyc = 0;
  always #10 core_clk = ~core_clk;
  // a first header word Z is a path the consumer does not know
  assign pathKnown = cmd.path[0] !== 8'h5a;
  scpmp_parser scpmp_parser_i (.*);
  scpmp_host scpmp_host_i (.*);
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (cmdValid && pathKnown && cmdReady) got.push_back(cmd);
    if (synErr) errs <= errs + 1;
    if (cyc == 20000)
    begin
      err_count++;
      tally_and_finish();
    end
  end
  task automatic check(input logic [63:0] act, input logic [63:0] exp);
    compares++;
    if (act !== exp)
    begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, act, exp);
    end
  endtask
  task automatic put(input scpmp_pkg::scpmp_resp_s r);
    @(negedge core_clk);
    resp = r;
    respValid = 1'b1;
    for (int k = 0; k < 400 && !respReady; k++) @(negedge core_clk);
    @(posedge core_clk);
    @(negedge core_clk);
    respValid = 1'b0;
  endtask
  task automatic test_suffix();
    string sfx[16] = '{"EXV", "PEV", "TV", "GV", "MAV", "KV", "MV", "UV", "NV", "PV", "FV",
                       "AV", "MHZ", "MOHM", "PCT", "DEG"};
    int e[16] = '{18, 15, 12, 9, 6, 3, -3, -6, -9, -12, -15, -18, 6, 6, 0, 0};
    int u[16] = '{3, 3, 3, 3, 3, 3, 3, 3, 3, 3, 3, 3, 1, 4, 5, 6};
    got.delete();
    for (int i = 0; i < 16; i++) scpmp_host_i.send({":A -1", sfx[i], "\n"}, 1'b0);
    repeat (3) @(negedge core_clk);
    for (int i = 0; i < 16; i++)
      check(got[i][44:0], {2'h3, 32'h1, 8'(e[i]), 3'(u[i])});
    $display("test_suffix done");
  endtask
  task automatic test_compound();
    got.delete();
    cmdReady = 1'b0;
    fork
      begin
        repeat (6) @(negedge core_clk);
        cmdReady = 1'b1;
      end
    join_none
    scpmp_host_i.send("*X;:A:B 1;C;:D?", 1'b1);
    repeat (4) @(negedge core_clk);
    check(got.size(), 4);
    check({got[0].common, got[2].depth, got[2].path[0], got[2].path[1]}, {1'b1, 3'h2, 16'h4143});
    check({got[3].depth, got[3].path[0], got[3].query}, {3'h1, 8'h44, 1'b1});
    $display("test_compound done");
  endtask
  task automatic test_error();
    got.delete();
    errs = 0;
    scpmp_host_i.send(":Z:Q 1;:Y?\n", 1'b1);
    repeat (3) @(negedge core_clk);
    check(errs, 1);
    check({got.size(), got[0].path[0], got[0].query}, {32'h1, 8'h59, 1'b1});
    $display("test_error done");
  endtask
  task automatic test_resp();
    string x = "-12,1234567890123456;1.23456789012345,1.5E-003;9.91E+037\n";
    logic [63:0] d = 64'h1234_5678_9012_3456;
    // reader stalls long enough for the queue to fill and refuse
    fork
      begin
        repeat (80) @(negedge core_clk);
        stall = 1'b0;
      end
    join_none
    put('{scpmp_pkg::FMT_NR1, 1'b1, 64'h12 << 56, 5'h02, 4'h1, 1'b0, 12'h000, 1'b0, 1'b0});
    put('{scpmp_pkg::FMT_NR1, 1'b0, d, 5'h11, 4'h1, 1'b0, 12'h000, 1'b1, 1'b0});
    put('{scpmp_pkg::FMT_NR2, 1'b0, d, 5'h10, 4'h1, 1'b0, 12'h000, 1'b0, 1'b0});
    put('{scpmp_pkg::FMT_NR3, 1'b0, 64'h15 << 56, 5'h02, 4'h1, 1'b1, 12'h003, 1'b1, 1'b0});
    put('{scpmp_pkg::FMT_NAN, 1'b0, 64'h0, 5'h00, 4'h0, 1'b0, 12'h000, 1'b0, 1'b1});
    for (int i = 0; i < 600 && scpmp_host_i.got.size() < x.len(); i++) @(negedge core_clk);
    check(scpmp_host_i.got.size(), x.len());
    for (int i = 0; i < x.len(); i++)
      check(scpmp_host_i.got[i], {i == x.len() - 1, x[i]});
    $display("test_resp done");
  endtask
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (3) @(negedge core_clk);
    rst = 1'b0;
    test_suffix();
    test_compound();
    test_error();
    test_resp();
    tally_and_finish();
  end
endmodule // tb_top

// ===== verilog/scpmp_fifo.sv
`timescale 1ns/1ps
module scpmp_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input  wire logic             core_clk, // clock
  input  wire logic             rst,      // async reset
  input  wire logic             flush,    // drop all words
  input  wire logic             inValid,  // write request
  output logic                  inReady,  // not full
  input  wire logic [WIDTH-1:0] inData,   // write word
  output logic                  outValid, // not empty
  input  wire logic             outReady, // read accept
  output logic [WIDTH-1:0]      outData   // head word
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] memReg [DEPTH];
  logic [AW:0]      wrReg;
  logic [AW:0]      rdReg;

  assign inReady  = (wrReg[AW] == rdReg[AW]) || (wrReg[AW-1:0] != rdReg[AW-1:0]);
  assign outValid = wrReg != rdReg;
  assign outData  = memReg[rdReg[AW-1:0]];

  always_ff @(posedge core_clk)
  begin
    if (inValid && inReady)
      memReg[wrReg[AW-1:0]] <= inData;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst) begin
      wrReg <= '0;
      rdReg <= '0;
    end else if (flush) begin
      wrReg <= '0;
      rdReg <= '0;
    end else begin
      if (inValid && inReady)
        wrReg <= wrReg + 1'b1;
      if (outValid && outReady)
        rdReg <= rdReg + 1'b1;
    end
  end
endmodule // scpmp_fifo

// ===== verilog/scpmp_parser.sv
// Behaviour
// - multipliers EX PE T G K U N P F A: powers of ten
// - MA is mega; M is mega before OHM or HZ, milli otherwise
// - accept HZ S V OHM PCT DEG; PCT and DEG take no multiplier
// - command ends on line feed, EOI with last byte, or both
// - semicolon splits commands of one message; each handled in turn
// - first command from root; later ones at previous command's level
// - colon right after semicolon restarts at root
// - header forming no valid path raises a syntax error
// - trailing question mark marks a query, answered into the output queue
// - response waits in queue until read or a new message arrives
// - program bytes flow in only; response bytes flow out only
// - comma between values of one query
// - semicolon between result groups of different queries
// - every response ends with line feed carrying EOI
// - integer response at most 16 digits and a sign
// - fixed-point response at most 15 digits, sign, point
// - exponent response at most 15 digits, sign, point, E, sign, 3 digits
// - unavailable float answered as 9.91E+037 in exponent form
`timescale 1ns/1ps
module scpmp_parser #(
  parameter int FIFO_DEPTH = 16
) (
  input  wire logic               core_clk,  // 50 MHz clock
  input  wire logic               rst,       // async reset, high
  input  wire logic [7:0]         rxByte,    // program byte
  input  wire logic               rxEoi,     // EOI with this byte
  input  wire logic               rxValid,   // byte offered
  output logic                    rxReady,   // byte taken
  output scpmp_pkg::scpmp_cmd_s   cmd,       // parsed command
  output logic                    cmdValid,  // command offered
  input  wire logic               pathKnown, // path of cmd is valid
  input  wire logic               cmdReady,  // consumer takes cmd
  output logic                    synErr,    // syntax error pulse
  input  wire scpmp_pkg::scpmp_resp_s resp,  // response item
  input  wire logic               respValid, // item offered
  output logic                    respReady, // item taken
  output logic [7:0]              txByte,    // response byte
  output logic                    txEoi,     // EOI with byte
  output logic                    txValid,   // byte available
  input  wire logic               txReady    // controller reads
);
  // ************************************************************
  // input parsing
  // ************************************************************
  typedef enum logic [7:0] {
    P_START = 8'h01, P_HDR = 8'h02, P_PRM = 8'h04, P_NUM = 8'h08,
    P_EXPQ  = 8'h10, P_EXP = 8'h20, P_SUF = 8'h40, P_SKIP = 8'h80
  } scpmp_pstate_e;

  scpmp_pstate_e        pState;
  logic [7:0]           pathReg [scpmp_pkg::MAX_DEPTH];
  logic [2:0]           depthReg, baseReg, cDepth;
  logic [7:0]           wordReg;
  logic                 wordAny, commonReg, queryReg, numAny, negReg;
  logic                 fracOn, expNeg, errReg, pendEnd, msgOpen;
  logic [31:0]          mantReg;
  logic [7:0]           fracCnt, expVal;
  logic [47:0]          sufBuf;
  logic [2:0]           sufLen;
  logic                 cmdValidReg, synErrReg;
  scpmp_pkg::scpmp_cmd_s cmdReg;

  logic       take, isLf, isSemi, finish, msgEnd, flushQ;
  logic       isDig, isAlpha, ovf;
  logic [7:0] ch;
  logic [3:0] dig;
  logic [11:0] sufDec;

  function automatic logic [7:0] upc(input logic [7:0] c);
    upc = (c >= 8'h61 && c <= 8'h7a) ? c - 8'h20 : c;
  endfunction

  // {err, unit, mult}
  function automatic logic [11:0] sufDecode(input logic [47:0] b, input logic [2:0] n);
    logic [2:0]        u;
    logic [2:0]        ul;
    logic [2:0]        pl;
    logic [15:0]       p;
    logic signed [7:0] m;
    logic              e;
    u = scpmp_pkg::U_NONE;
    ul = 3'h0;
    m = 8'sd0;
    e = 1'b0;
    if (b[23:0] == "OHM" && n >= 3'h3) begin u = scpmp_pkg::U_OHM; ul = 3'h3; end
    else if (b[23:0] == "PCT" && n >= 3'h3) begin u = scpmp_pkg::U_PCT; ul = 3'h3; end
    else if (b[23:0] == "DEG" && n >= 3'h3) begin u = scpmp_pkg::U_DEG; ul = 3'h3; end
    else if (b[15:0] == "HZ" && n >= 3'h2) begin u = scpmp_pkg::U_HZ; ul = 3'h2; end
    else if (b[7:0] == "S" && n >= 3'h1) begin u = scpmp_pkg::U_S; ul = 3'h1; end
    else if (b[7:0] == "V" && n >= 3'h1) begin u = scpmp_pkg::U_V; ul = 3'h1; end
    else if (n != 3'h0) e = 1'b1;
    pl = n - ul;
    p = b[ul*8 +: 16];
    if (pl == 3'h1) begin
      case (p[7:0])
        "T": m = scpmp_pkg::MUL_TERA;
        "G": m = scpmp_pkg::MUL_GIGA;
        "K": m = scpmp_pkg::MUL_KILO;
        "U": m = scpmp_pkg::MUL_MICRO;
        "N": m = scpmp_pkg::MUL_NANO;
        "P": m = scpmp_pkg::MUL_PICO;
        "F": m = scpmp_pkg::MUL_FEMTO;
        "A": m = scpmp_pkg::MUL_ATTO;
        "M": m = (u == scpmp_pkg::U_OHM || u == scpmp_pkg::U_HZ) ?
                 scpmp_pkg::MUL_MEGA : scpmp_pkg::MUL_MILLI;
        default: e = 1'b1;
      endcase
    end else if (pl == 3'h2) begin
      if (p == "EX") m = scpmp_pkg::MUL_EXA;
      else if (p == "PE") m = scpmp_pkg::MUL_PETA;
      else if (p == "MA") m = scpmp_pkg::MUL_MEGA;
      else e = 1'b1;
    end else if (pl != 3'h0) e = 1'b1;
    if (pl != 3'h0 && (u == scpmp_pkg::U_PCT || u == scpmp_pkg::U_DEG))
      e = 1'b1;
    sufDecode = {e, u, m};
  endfunction

  assign ch      = upc(rxByte);
  assign rxReady = !cmdValidReg && !pendEnd;
  assign take    = rxValid && rxReady;
  assign isLf    = ch == scpmp_pkg::CH_LF;
  assign isSemi  = ch == scpmp_pkg::CH_SEMI;
  assign finish  = pendEnd || (take && (isLf || isSemi));
  assign msgEnd  = pendEnd || (take && (isLf || rxEoi));
  assign flushQ  = take && !msgOpen;
  assign isDig   = ch >= 8'h30 && ch <= 8'h39;
  assign isAlpha = ch >= 8'h41 && ch <= 8'h5a;
  assign dig     = ch[3:0];
  assign cDepth  = depthReg + {2'b00, wordAny};
  assign ovf     = wordAny && depthReg == 3'(scpmp_pkg::MAX_DEPTH);
  assign sufDec  = sufDecode(sufBuf, sufLen);
  assign cmd      = cmdReg;
  assign cmdValid = cmdValidReg;
  assign synErr   = synErrReg;

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst) begin
      pState <= P_START;
      for (int i = 0; i < scpmp_pkg::MAX_DEPTH; i++)
        pathReg[i] <= 8'h00;
      depthReg <= 3'h0; baseReg <= 3'h0; wordReg <= 8'h00;
      wordAny <= 1'b0; commonReg <= 1'b0; queryReg <= 1'b0;
      numAny <= 1'b0; negReg <= 1'b0; fracOn <= 1'b0; expNeg <= 1'b0;
      errReg <= 1'b0; pendEnd <= 1'b0; msgOpen <= 1'b0;
      mantReg <= 32'h0; fracCnt <= 8'h00; expVal <= 8'h00;
      sufBuf <= 48'h0; sufLen <= 3'h0;
      cmdValidReg <= 1'b0; synErrReg <= 1'b0; cmdReg <= '0;
    end else begin
      synErrReg <= 1'b0;
      if (cmdValidReg && (!pathKnown || cmdReady)) begin
        cmdValidReg <= 1'b0;
        if (!pathKnown)
          synErrReg <= 1'b1;
      end
      if (take && !msgOpen)
        msgOpen <= 1'b1;
      if (take && !isLf && !isSemi) begin
        if (rxEoi)
          pendEnd <= 1'b1;
        case (pState)
          P_START:
          begin
            if (ch == scpmp_pkg::CH_COLON) begin
              depthReg <= 3'h0;
              pState <= P_HDR;
            end else if (ch == scpmp_pkg::CH_STAR) begin
              commonReg <= 1'b1;
              depthReg <= 3'h0;
              pState <= P_HDR;
            end else if (isAlpha) begin
              depthReg <= baseReg;
              wordReg <= ch;
              wordAny <= 1'b1;
              pState <= P_HDR;
            end else if (ch != scpmp_pkg::CH_SPACE) begin
              errReg <= 1'b1;
              pState <= P_SKIP;
            end
          end
          P_HDR:
          begin
            if (isAlpha || isDig) begin
              wordReg <= {wordReg[6:0], wordReg[7]} ^ ch;
              wordAny <= 1'b1;
            end else if (ch == scpmp_pkg::CH_COLON || ch == scpmp_pkg::CH_QUERY ||
                         ch == scpmp_pkg::CH_SPACE) begin
              if (ovf || (!wordAny && ch == scpmp_pkg::CH_COLON))
                errReg <= 1'b1;
              else if (wordAny)
                pathReg[depthReg[1:0]] <= wordReg;
              depthReg <= ovf ? depthReg : cDepth;
              wordReg <= 8'h00;
              wordAny <= 1'b0;
              if (ch == scpmp_pkg::CH_QUERY)
                queryReg <= 1'b1;
              if (ch != scpmp_pkg::CH_COLON)
                pState <= P_PRM;
            end else begin
              errReg <= 1'b1;
              pState <= P_SKIP;
            end
          end
          P_PRM:
          begin
            if (isDig || ch == scpmp_pkg::CH_MINUS || ch == scpmp_pkg::CH_PLUS ||
                ch == scpmp_pkg::CH_DOT) begin
              numAny <= 1'b1;
              negReg <= ch == scpmp_pkg::CH_MINUS;
              fracOn <= ch == scpmp_pkg::CH_DOT;
              mantReg <= isDig ? {28'h0, dig} : 32'h0;
              pState <= P_NUM;
            end else if (ch != scpmp_pkg::CH_SPACE)
              pState <= P_SKIP;
          end
          P_NUM:
          begin
            if (isDig) begin
              mantReg <= 32'(mantReg * 32'd10 + {28'h0, dig});
              if (fracOn)
                fracCnt <= fracCnt + 8'h01;
            end else if (ch == scpmp_pkg::CH_DOT && !fracOn)
              fracOn <= 1'b1;
            else if (ch == scpmp_pkg::CH_E)
              pState <= P_EXPQ;
            else if (ch == scpmp_pkg::CH_SPACE)
              pState <= P_SUF;
            else if (isAlpha) begin
              sufBuf <= {sufBuf[39:0], ch};
              sufLen <= 3'h1;
              pState <= P_SUF;
            end else if (ch == scpmp_pkg::CH_COMMA)
              pState <= P_SKIP;
            else begin
              errReg <= 1'b1;
              pState <= P_SKIP;
            end
          end
          P_EXPQ:
          begin
            // E is an exponent only when a digit or sign follows
            if (isDig || ch == scpmp_pkg::CH_MINUS || ch == scpmp_pkg::CH_PLUS) begin
              expNeg <= ch == scpmp_pkg::CH_MINUS;
              expVal <= isDig ? {4'h0, dig} : 8'h00;
              pState <= P_EXP;
            end else begin
              sufBuf <= isAlpha ? {sufBuf[31:0], scpmp_pkg::CH_E, ch} :
                                  {sufBuf[39:0], scpmp_pkg::CH_E};
              sufLen <= isAlpha ? 3'h2 : 3'h1;
              pState <= P_SUF;
            end
          end
          P_EXP, P_SUF:
          begin
            if (isDig && pState == P_EXP)
              expVal <= 8'(expVal * 8'd10 + {4'h0, dig});
            else if (isAlpha) begin
              if (sufLen == 3'(scpmp_pkg::SUF_CHARS))
                errReg <= 1'b1;
              sufBuf <= {sufBuf[39:0], ch};
              sufLen <= sufLen + 3'h1;
              pState <= P_SUF;
            end else if (ch == scpmp_pkg::CH_SPACE)
              pState <= P_SUF;
            else if (ch == scpmp_pkg::CH_COMMA)
              pState <= P_SKIP;
            else begin
              errReg <= 1'b1;
              pState <= P_SKIP;
            end
          end
          P_SKIP: ;
          default: pState <= P_SKIP;
        endcase
      end
      if (finish) begin
        if (cDepth != 3'h0 || commonReg || errReg) begin
          if (errReg || sufDec[11] || (ovf && pState == P_HDR))
            synErrReg <= 1'b1;
          else begin
            cmdValidReg <= 1'b1;
            for (int i = 0; i < scpmp_pkg::MAX_DEPTH; i++)
              cmdReg.path[i] <= (pState == P_HDR && wordAny && depthReg == 3'(i)) ?
                                wordReg : pathReg[i];
            cmdReg.depth  <= cDepth;
            cmdReg.common <= commonReg;
            cmdReg.query  <= queryReg;
            cmdReg.hasNum <= numAny;
            cmdReg.neg    <= negReg;
            cmdReg.mant   <= mantReg;
            cmdReg.exp10  <= (expNeg ? -$signed(expVal) : $signed(expVal))
                             - $signed(fracCnt) + $signed(sufDec[7:0]);
            cmdReg.unit   <= scpmp_pkg::scpmp_unit_e'(sufDec[10:8]);
          end
        end
        if (pState == P_HDR && wordAny && !ovf)
          pathReg[depthReg[1:0]] <= wordReg;
        if (msgEnd)
          baseReg <= 3'h0;
        else if (!commonReg && cDepth != 3'h0)
          baseReg <= cDepth - 3'h1;
        if (msgEnd)
          msgOpen <= 1'b0;
        pState <= P_START; depthReg <= 3'h0;
        wordReg <= 8'h00; wordAny <= 1'b0; commonReg <= 1'b0;
        queryReg <= 1'b0; numAny <= 1'b0; negReg <= 1'b0;
        fracOn <= 1'b0; expNeg <= 1'b0; errReg <= 1'b0; pendEnd <= 1'b0;
        mantReg <= 32'h0; fracCnt <= 8'h00; expVal <= 8'h00; sufLen <= 3'h0;
      end
    end
  end

  // ************************************************************
  // response formatting
  // ************************************************************
  typedef enum logic [7:0] {
    F_IDLE = 8'h01, F_SIGN = 8'h02, F_DIG = 8'h04, F_PT  = 8'h08,
    F_EXPE = 8'h10, F_EXPS = 8'h20, F_EXPD = 8'h40, F_SEP = 8'h80
  } scpmp_fstate_e;

  scpmp_fstate_e         fState;
  scpmp_pkg::scpmp_resp_s itemReg;
  logic [4:0]            digLeft;
  logic [3:0]            intLeft;
  logic [1:0]            expLeft;
  logic                  fValid, fReady, isNr3;
  logic [4:0]            nd;
  scpmp_pkg::scpmp_tx_s  fChar, outWord;

  assign respReady = fState == F_IDLE;
  assign fValid    = fState != F_IDLE;
  assign isNr3     = itemReg.fmt == scpmp_pkg::FMT_NR3;
  // digit budget per format
  assign nd = (resp.fmt == scpmp_pkg::FMT_NR1) ?
              ((resp.nDig > scpmp_pkg::NR1_DIGITS) ? scpmp_pkg::NR1_DIGITS : resp.nDig) :
              ((resp.nDig > scpmp_pkg::NRX_DIGITS) ? scpmp_pkg::NRX_DIGITS : resp.nDig);

  always_comb
  begin
    fChar.eoi = 1'b0;
    case (fState)
      F_SIGN: fChar.data = scpmp_pkg::CH_MINUS;
      F_DIG:  fChar.data = scpmp_pkg::CH_ZERO | {4'h0, itemReg.digits[63:60]};
      F_PT:   fChar.data = scpmp_pkg::CH_DOT;
      F_EXPE: fChar.data = scpmp_pkg::CH_E;
      F_EXPS: fChar.data = itemReg.expNeg ? scpmp_pkg::CH_MINUS : scpmp_pkg::CH_PLUS;
      F_EXPD: fChar.data = scpmp_pkg::CH_ZERO | {4'h0, itemReg.expBcd[11:8]};
      F_SEP:
      begin
        fChar.eoi  = itemReg.lastMsg;
        fChar.data = itemReg.lastMsg ? scpmp_pkg::CH_LF :
                     itemReg.lastGroup ? scpmp_pkg::CH_SEMI :
                     scpmp_pkg::CH_COMMA;
      end
      default: fChar.data = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst) begin
      fState <= F_IDLE;
      itemReg <= '0;
      digLeft <= 5'h0;
      intLeft <= 4'h0;
      expLeft <= 2'h0;
    end else if (fState == F_IDLE) begin
      if (respValid) begin
        itemReg <= resp;
        digLeft <= (nd == 5'h0) ? 5'h1 : nd;
        intLeft <= (resp.pointPos == 4'h0) ? 4'h1 : resp.pointPos;
        fState <= resp.neg ? F_SIGN : F_DIG;
        if (resp.fmt == scpmp_pkg::FMT_NAN) begin
          itemReg.fmt      <= scpmp_pkg::FMT_NR3;
          itemReg.neg      <= 1'b0;
          itemReg.digits   <= scpmp_pkg::NAN_MANT;
          itemReg.expNeg   <= 1'b0;
          itemReg.expBcd   <= scpmp_pkg::NAN_EXP;
          digLeft <= scpmp_pkg::NAN_NDIG;
          intLeft <= scpmp_pkg::NAN_POINT;
          fState  <= F_DIG;
        end
      end
    end else if (fReady) begin
      case (fState)
        F_SIGN: fState <= F_DIG;
        F_DIG:
        begin
          itemReg.digits <= {itemReg.digits[59:0], 4'h0};
          digLeft <= digLeft - 5'h1;
          intLeft <= intLeft - 4'h1;
          if (digLeft == 5'h1)
            fState <= isNr3 ? F_EXPE : F_SEP;
          else if (intLeft == 4'h1 && itemReg.fmt != scpmp_pkg::FMT_NR1)
            fState <= F_PT;
        end
        F_PT:   fState <= F_DIG;
        F_EXPE: fState <= F_EXPS;
        F_EXPS:
        begin
          expLeft <= scpmp_pkg::EXP_DIGITS;
          fState <= F_EXPD;
        end
        F_EXPD:
        begin
          itemReg.expBcd <= {itemReg.expBcd[7:0], 4'h0};
          expLeft <= expLeft - 2'h1;
          if (expLeft == 2'h1)
            fState <= F_SEP;
        end
        F_SEP:   fState <= F_IDLE;
        default: fState <= F_IDLE;
      endcase
    end
  end

  // ************************************************************
  // output queue
  // ************************************************************
  scpmp_fifo #(
    .WIDTH ($bits(scpmp_pkg::scpmp_tx_s)),
    .DEPTH (FIFO_DEPTH)
  ) u_queue (
    .core_clk (core_clk),
    .rst      (rst),
    .flush    (flushQ),
    .inValid  (fValid),
    .inReady  (fReady),
    .inData   (fChar),
    .outValid (txValid),
    .outReady (txReady),
    .outData  (outWord)
  );

  assign txByte = outWord.data;
  assign txEoi  = outWord.eoi;
endmodule // scpmp_parser

// ===== verilog/scpmp_pkg.sv
package scpmp_pkg;

  // ************************************************************
  // characters
  // ************************************************************
  localparam logic [7:0] CH_LF    = 8'h0a;
  localparam logic [7:0] CH_SPACE = 8'h20;
  localparam logic [7:0] CH_STAR  = 8'h2a;
  localparam logic [7:0] CH_PLUS  = 8'h2b;
  localparam logic [7:0] CH_COMMA = 8'h2c;
  localparam logic [7:0] CH_MINUS = 8'h2d;
  localparam logic [7:0] CH_DOT   = 8'h2e;
  localparam logic [7:0] CH_ZERO  = 8'h30;
  localparam logic [7:0] CH_COLON = 8'h3a;
  localparam logic [7:0] CH_SEMI  = 8'h3b;
  localparam logic [7:0] CH_QUERY = 8'h3f;
  localparam logic [7:0] CH_E     = 8'h45;

  // ************************************************************
  // limits and special values
  // ************************************************************
  localparam int          MAX_DEPTH  = 4;
  localparam int          SUF_CHARS  = 6;
  localparam logic [4:0]  NR1_DIGITS = 5'h10;
  localparam logic [4:0]  NRX_DIGITS = 5'h0f;
  localparam logic [1:0]  EXP_DIGITS = 2'h3;
  localparam logic [63:0] NAN_MANT   = 64'h9910_0000_0000_0000;
  localparam logic [4:0]  NAN_NDIG   = 5'h03;
  localparam logic [3:0]  NAN_POINT  = 4'h1;
  localparam logic [11:0] NAN_EXP    = 12'h037;

  // ************************************************************
  // suffix multipliers as powers of ten
  // ************************************************************
  localparam logic signed [7:0] MUL_EXA   = 8'sd18;
  localparam logic signed [7:0] MUL_PETA  = 8'sd15;
  localparam logic signed [7:0] MUL_TERA  = 8'sd12;
  localparam logic signed [7:0] MUL_GIGA  = 8'sd9;
  localparam logic signed [7:0] MUL_MEGA  = 8'sd6;
  localparam logic signed [7:0] MUL_KILO  = 8'sd3;
  localparam logic signed [7:0] MUL_MILLI = -8'sd3;
  localparam logic signed [7:0] MUL_MICRO = -8'sd6;
  localparam logic signed [7:0] MUL_NANO  = -8'sd9;
  localparam logic signed [7:0] MUL_PICO  = -8'sd12;
  localparam logic signed [7:0] MUL_FEMTO = -8'sd15;
  localparam logic signed [7:0] MUL_ATTO  = -8'sd18;

  typedef enum logic [2:0] {
    U_NONE = 3'h0, U_HZ = 3'h1, U_S = 3'h2, U_V = 3'h3,
    U_OHM  = 3'h4, U_PCT = 3'h5, U_DEG = 3'h6
  } scpmp_unit_e;

  typedef enum logic [1:0] {
    FMT_NR1 = 2'h0, FMT_NR2 = 2'h1, FMT_NR3 = 2'h2, FMT_NAN = 2'h3
  } scpmp_fmt_e;

  typedef struct packed {
    logic [3:0][7:0]   path;
    logic [2:0]        depth;
    logic              common;
    logic              query;
    logic              hasNum;
    logic              neg;
    logic [31:0]       mant;
    logic signed [7:0] exp10;
    scpmp_unit_e       unit;
  } scpmp_cmd_s;

  typedef struct packed {
    scpmp_fmt_e  fmt;
    logic        neg;
    logic [63:0] digits;
    logic [4:0]  nDig;
    logic [3:0]  pointPos;
    logic        expNeg;
    logic [11:0] expBcd;
    logic        lastGroup;
    logic        lastMsg;
  } scpmp_resp_s;

  typedef struct packed {
    logic       eoi;
    logic [7:0] data;
  } scpmp_tx_s;

endpackage
